// *** csp_config_port.sv ***
// Serial configuration port: frame shifter, command decoder and register file
// Notes on behaviour
// - Sample on rising clock, change on falling.
// - Latch enable low starts; high blocks shifting.
// - Serial output open drain, never driven high.
// - Bit 0 taken at first rising edge.
// - Latch enable rising ends frame, word acted.
// - Code in bits 3..0, data above.
// - Write loads data into register 0,1,2.
// - Frame end decodes read address field.
// - Next frame shifts selected register out.
// - Code 1111, data one copies to store.
// - Copy command reusable, needs no unlock.
// - After reset, store loads configuration registers.
module csp_config_port
  import csp_pkg::*;
#(
  parameter int unsigned STORE_WAIT = CSP_STORE_CYCLES
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_MOSI,
  input wire logic FRAME_LATCH_ENABLE,
  input wire logic SPI_MISO_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE,
  output logic [27:0] CFG_WORD_ZERO,
  output logic [27:0] CFG_WORD_ONE,
  output logic [27:0] STATUS_CONTROL,
  output logic STORE_BUSY
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] rx_shift_reg;
  logic [4:0] tx_cnt_reg;
  logic le_s1_reg;
  logic le_s2_reg;
  logic le_s3_reg;
  logic frame_end;
  csp_frame_t frame;
  csp_cfg_t cfg_reg;
  csp_cfg_t cfg_next;
  csp_state_t state_reg;
  csp_state_t state_next;
  logic [31:0] tx_word_reg;
  logic tx_en_reg;
  logic [20:0] wait_reg;
  logic wait_done;
  logic nv_wr_en;
  logic nv_wr_addr;
  logic [27:0] nv_wr_data;
  logic nv_rd_addr;
  logic [27:0] nv_rd_data;
  logic is_read;
  logic is_copy;
  logic [27:0] read_value;
  logic miso_i_unused;

  // ----------------------------------------------------------------
  // Link side; shifter and bit index clocked by the serial clock
  // ----------------------------------------------------------------

  // Shift in on rising edges, LSB first, only inside a frame
  always_ff @(posedge SPI_SCLK)
  begin
    if (!FRAME_LATCH_ENABLE)
    begin
      rx_shift_reg <= {SPI_MOSI, rx_shift_reg[31:1]};
    end
  end

  // Output bit index moves on falling edges; cleared while no frame runs
  always_ff @(negedge SPI_SCLK or posedge FRAME_LATCH_ENABLE)
  begin
    if (FRAME_LATCH_ENABLE)
    begin
      tx_cnt_reg <= 5'h00;
    end
    else
    begin
      tx_cnt_reg <= tx_cnt_reg + 5'h01;
    end
  end

  // Open drain: the low level is fixed, only the enable moves
  always_ff @(posedge CLK_SYS)
  begin
    SPI_MISO_O <= 1'b0;
  end

  // Pull low for a zero bit of the read word, release for a one
  assign SPI_MISO_OE = tx_en_reg & ~FRAME_LATCH_ENABLE & ~tx_word_reg[tx_cnt_reg];

  // The pin level is not looked at by this end
  assign miso_i_unused = SPI_MISO_I;

  // ----------------------------------------------------------------
  // Frame end crossing into the system clock
  // ----------------------------------------------------------------

  // Two flip-flops for the level, a third for the edge
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      le_s1_reg <= 1'b1;
      le_s2_reg <= 1'b1;
      le_s3_reg <= 1'b1;
    end
    else
    begin
      le_s1_reg <= FRAME_LATCH_ENABLE;
      le_s2_reg <= le_s1_reg;
      le_s3_reg <= le_s2_reg;
    end
  end

  // Serial clock has stopped, so the shifted word is steady here
  assign frame_end = le_s2_reg & ~le_s3_reg;
  assign frame = csp_frame_t'(rx_shift_reg);
  assign is_read = (frame.code == CSP_CODE_READ) && ((frame.data & CSP_READ_MASK) == '0);
  assign is_copy = (frame.code == CSP_CODE_COPY) && (frame.data == CSP_COPY_DATA);

  // ----------------------------------------------------------------
  // Sequencer: power-up load, idle, nonvolatile copy
  // ----------------------------------------------------------------

  assign wait_done = (wait_reg == CSP_WAIT_W'(STORE_WAIT - 1));

  // Next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CSP_ST_LOAD0: state_next = CSP_ST_LOAD1;
      CSP_ST_LOAD1: state_next = CSP_ST_LOAD2;
      CSP_ST_LOAD2: state_next = CSP_ST_IDLE;
      CSP_ST_IDLE:
      begin
        if (frame_end && is_copy)
        begin
          state_next = CSP_ST_STORE;
        end
      end
      CSP_ST_STORE: state_next = CSP_ST_WAIT;
      CSP_ST_WAIT:
      begin
        if (wait_done)
        begin
          state_next = CSP_ST_IDLE;
        end
      end
    endcase
  end

  // State register; reset starts the load from the store
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      state_reg <= CSP_ST_LOAD0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Write-time counter while the store completes
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N || state_reg != CSP_ST_WAIT)
    begin
      wait_reg <= '0;
    end
    else
    begin
      wait_reg <= wait_reg + 21'h000001;
    end
  end

  // Store ports: read word 0 then 1 at load, write both on copy
  assign nv_rd_addr = (state_reg == CSP_ST_LOAD1);
  assign nv_wr_en = (state_reg == CSP_ST_IDLE && frame_end && is_copy) ||
                    (state_reg == CSP_ST_STORE);
  assign nv_wr_addr = (state_reg == CSP_ST_STORE);
  assign nv_wr_data = nv_wr_addr ? cfg_reg.word_one : cfg_reg.word_zero;

  csp_nv_store u_store (
    .clk(CLK_SYS),
    .wr_en(nv_wr_en),
    .wr_addr(nv_wr_addr),
    .wr_data(nv_wr_data),
    .rd_addr(nv_rd_addr),
    .rd_data(nv_rd_data)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Next register values from load and write frames
  always_comb
  begin
    cfg_next = cfg_reg;
    if (state_reg == CSP_ST_LOAD1)
    begin
      cfg_next.word_zero = nv_rd_data;
    end
    if (state_reg == CSP_ST_LOAD2)
    begin
      cfg_next.word_one = nv_rd_data;
    end
    if (state_reg == CSP_ST_IDLE && frame_end)
    begin
      unique case (frame.code)
        CSP_CODE_CFG0: cfg_next.word_zero = frame.data;
        CSP_CODE_CFG1: cfg_next.word_one = frame.data;
        CSP_CODE_STAT: cfg_next.status = frame.data;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // Register state
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      cfg_reg <= '{CSP_WORD_RST, CSP_WORD_RST, CSP_WORD_RST};
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Selected word; the status word shows the store busy flag on top
  always_comb
  begin
    read_value = CSP_WORD_RST;
    unique case (frame.data[3:0])
      CSP_CODE_CFG0: read_value = cfg_reg.word_zero;
      CSP_CODE_CFG1: read_value = cfg_reg.word_one;
      CSP_CODE_STAT:
      begin
        read_value = cfg_reg.status;
        read_value[CSP_STAT_BUSY_BIT] = (state_reg != CSP_ST_IDLE);
      end
      default: read_value = CSP_WORD_RST;
    endcase
  end

  // Arm the next frame with the word; a later frame end disarms it unless it is itself a valid read
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      tx_en_reg <= 1'b0;
      tx_word_reg <= '0;
    end
    else if (frame_end)
    begin
      tx_en_reg <= (state_reg == CSP_ST_IDLE) && is_read &&
                   (frame.data[3:0] < CSP_NV_WORDS + 4'h1);
      tx_word_reg <= {read_value, frame.data[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Configuration and busy flag leave from flip-flops
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      CFG_WORD_ZERO <= CSP_WORD_RST;
      CFG_WORD_ONE <= CSP_WORD_RST;
      STATUS_CONTROL <= CSP_WORD_RST;
      STORE_BUSY <= 1'b1;
    end
    else
    begin
      CFG_WORD_ZERO <= cfg_next.word_zero;
      CFG_WORD_ONE <= cfg_next.word_one;
      STATUS_CONTROL <= cfg_next.status;
      STORE_BUSY <= (state_next != CSP_ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  sequence frame_done_s;
    frame_end && state_reg == CSP_ST_IDLE;
  endsequence

  sequence copy_frame_s;
    frame_done_s ##0 is_copy;
  endsequence

  write_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    frame_done_s ##0 frame.code == CSP_CODE_CFG0 |=> cfg_reg.word_zero == $past(frame.data))
    else $error("register zero not written");

  ignore_code_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    frame_done_s ##0 (frame.code > CSP_CODE_STAT && !is_read && !is_copy)
    |=> $stable(cfg_reg))
    else $error("unknown code changed a register");

  read_arm_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    frame_done_s ##0 is_read ##0 frame.data[3:0] == CSP_CODE_CFG1
    |=> tx_en_reg && tx_word_reg[31:4] == $past(cfg_reg.word_one))
    else $error("read word not armed");

  copy_start_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    copy_frame_s |-> nv_wr_en && !nv_wr_addr ##1 nv_wr_en && nv_wr_addr ##1
    state_reg == CSP_ST_WAIT)
    else $error("copy did not write both words");

  copy_again_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    state_reg == CSP_ST_WAIT && wait_done |=> state_reg == CSP_ST_IDLE && !STORE_BUSY)
    else $error("copy command not usable again");

  load_after_reset_a: assert property (@(posedge CLK_SYS)
    !RESET_N ##1 RESET_N [*3] |=> state_reg == CSP_ST_IDLE)
    else $error("power-up load did not finish");

  frame_edge_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(le_s2_reg) |-> frame_end ##1 !frame_end)
    else $error("frame end not one pulse");

  hold_shift_a: assert property (@(posedge SPI_SCLK) disable iff (!RESET_N)
    FRAME_LATCH_ENABLE ##1 FRAME_LATCH_ENABLE |-> $stable(rx_shift_reg))
    else $error("shifted while latch enable high");

  open_drain_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    SPI_MISO_OE |-> tx_en_reg && !SPI_MISO_O)
    else $error("serial output driven without read");

endmodule // csp_config_port

// *** csp_pkg.sv ***
// Constants, field layouts and types shared by the serial configuration port
package csp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned CSP_FRAME_W = 32;
  localparam int unsigned CSP_CODE_W = 4;
  localparam int unsigned CSP_DATA_W = 28;
  localparam int unsigned CSP_CNT_W = 5;

  // ----------------------------------------------------------------
  // Address and command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CSP_CODE_CFG0 = 4'h0;
  localparam logic [3:0] CSP_CODE_CFG1 = 4'h1;
  localparam logic [3:0] CSP_CODE_STAT = 4'h2;
  localparam logic [3:0] CSP_CODE_READ = 4'he;
  localparam logic [3:0] CSP_CODE_COPY = 4'hf;
  localparam logic [27:0] CSP_COPY_DATA = 28'h0000001;
  localparam logic [27:0] CSP_READ_MASK = 28'hffffff0;

  // ----------------------------------------------------------------
  // Reset values and status field
  // ----------------------------------------------------------------
  localparam logic [27:0] CSP_WORD_RST = 28'h0000000;
  localparam logic [27:0] CSP_CFG0_DEFAULT = 28'h0000000;
  localparam logic [27:0] CSP_CFG1_DEFAULT = 28'h0000000;
  localparam int unsigned CSP_STAT_BUSY_BIT = 27;
  localparam logic [3:0] CSP_NV_WORDS = 4'h2;

  // ----------------------------------------------------------------
  // Timing of the nonvolatile write
  // ----------------------------------------------------------------
  localparam int unsigned CSP_CLK_HZ = 25000000;
  localparam int unsigned CSP_STORE_TIME_MS = 50;
  localparam int unsigned CSP_STORE_CYCLES = CSP_STORE_TIME_MS * (CSP_CLK_HZ / 1000);
  localparam int unsigned CSP_WAIT_W = 21;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [27:0] data;
    logic [3:0] code;
  } csp_frame_t;

  typedef struct packed {
    logic [27:0] word_zero;
    logic [27:0] word_one;
    logic [27:0] status;
  } csp_cfg_t;

  typedef enum logic [5:0] {
    CSP_ST_LOAD0 = 6'h01,
    CSP_ST_LOAD1 = 6'h02,
    CSP_ST_LOAD2 = 6'h04,
    CSP_ST_IDLE = 6'h08,
    CSP_ST_STORE = 6'h10,
    CSP_ST_WAIT = 6'h20
  } csp_state_t;

endpackage

// *** csp_nv_store.sv ***
// Two-word nonvolatile store with registered read data
module csp_nv_store
  import csp_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic wr_addr,
  input wire logic [27:0] wr_data,
  input wire logic rd_addr,
  output logic [27:0] rd_data
);

  // Contents survive reset; the initialiser stands for the programmed image
  logic [27:0] mem [2] = '{CSP_CFG0_DEFAULT, CSP_CFG1_DEFAULT};

  // Write port
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data come out of a register
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule // csp_nv_store

// *** csp_host_model.sv ***
// Host side model of the serial configuration link
module csp_host_model
  import csp_pkg::*;
(
  output logic sclk,
  output logic mosi,
  output logic frame_latch_enable,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Clock stands low and the frame line high between frames
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    frame_latch_enable = 1'b1;
  end

  // ----------------------------------------------------------------
  // Framed transfer
  // ----------------------------------------------------------------
  // One 32-bit frame, LSB first, answer sampled on each rising edge
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    begin
      #7 frame_latch_enable = 1'b0;
      for (int i = 0; i < CSP_FRAME_W; i++)
      begin
        mosi = tx[i];
        #24 sclk = 1'b1;
        rx[i] = miso;
        #24 sclk = 1'b0;
      end
      mosi = ~tx[31]; // Released line shows no stale bit
      #24 frame_latch_enable = 1'b1;
      #200; // Gap long enough for the frame end to be seen
    end
  endtask

  // Stray clock pulses with the frame line high; the port must ignore them
  task automatic stray(input int n);
    begin
      for (int i = 0; i < n; i++)
      begin
        mosi = ~mosi;
        #24 sclk = 1'b1;
        #24 sclk = 1'b0;
      end
      #200;
    end
  endtask
endmodule // csp_host_model

// *** csp_config_port_test.sv ***
// Self-checking testbench of the serial configuration port
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
  end

module csp_config_port_test
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [31:0] frm;
    logic [27:0] e0;
    logic [27:0] e1;
    logic [27:0] e2;
  } csp_row_t;

  localparam int unsigned WAIT_N = 100;
  localparam logic [27:0] K0 = 28'h1234567;
  localparam logic [27:0] K1 = 28'hfedcba9;
  localparam logic [27:0] K2 = 28'hda5a5a5;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, mosi, le, miso_o, miso_oe, busy;
  wire logic miso_wire;
  logic [27:0] cfg0, cfg1, stat;
  logic [31:0] rx;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  csp_row_t rows [7] = '{
    '{{K0, CSP_CODE_CFG0}, K0, 28'h0, 28'h0},
    '{{K1, CSP_CODE_CFG1}, K0, K1, 28'h0},
    '{{K2, CSP_CODE_STAT}, K0, K1, K2},
    '{{28'hfffffff, 4'h3}, K0, K1, K2},
    '{{28'h0000000, 4'hd}, K0, K1, K2},
    '{{28'h0000003, CSP_CODE_COPY}, K0, K1, K2},
    '{{28'h0000001, CSP_CODE_READ}, K0, K1, K2}
  };

  // ----------------------------------------------------------------
  // Clock, open-drain wire and instances
  // ----------------------------------------------------------------
  // System clock of 40 ns
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Pull-up wins unless the port pulls low
  assign miso_wire = miso_oe ? miso_o : 1'b1;

  csp_config_port #(.STORE_WAIT(WAIT_N)) dut_u (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .SPI_SCLK(sclk), .SPI_MOSI(mosi),
    .FRAME_LATCH_ENABLE(le), .SPI_MISO_I(miso_wire), .SPI_MISO_O(miso_o),
    .SPI_MISO_OE(miso_oe), .CFG_WORD_ZERO(cfg0), .CFG_WORD_ONE(cfg1),
    .STATUS_CONTROL(stat), .STORE_BUSY(busy)
  );

  csp_host_model host_u (
    .sclk(sclk), .mosi(mosi), .frame_latch_enable(le), .miso(miso_wire)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Read command, then an ignored-code frame that carries the answer out
  task automatic rd_chk(input logic [27:0] d, input logic [31:0] e);
    begin
      host_u.xfer({d, CSP_CODE_READ}, rx);
      host_u.xfer(32'h00000003, rx);
      `CHK("read", e, rx);
      `CHK("miso_o", 1'b0, miso_o);
    end
  endtask

  task automatic stop_test();
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(3);
    `CHK("busy_rst", 1'b1, busy);
    tick(2);
    reset_n <= 1'b1;
    tick(8);
    `CHK("busy_load", 1'b0, busy);
    `CHK("cfg0_load", CSP_CFG0_DEFAULT, cfg0);
    // Ordinary frames, back to back
    foreach (rows[i])
    begin
      host_u.xfer(rows[i].frm, rx);
      tick(2);
      `CHK("cfg0", rows[i].e0, cfg0);
      `CHK("cfg1", rows[i].e1, cfg1);
      `CHK("stat", rows[i].e2, stat);
    end
    // Clock pulses outside a frame must not disturb anything
    host_u.stray(3);
    `CHK("cfg0_stray", K0, cfg0);
    // Read-back of each register and refused reads
    rd_chk(28'h0, {K0, CSP_CODE_CFG0});
    rd_chk(28'h1, {K1, CSP_CODE_CFG1});
    rd_chk(28'h2, {1'b0, K2[26:0], CSP_CODE_STAT});
    rd_chk(28'h3, 32'hffffffff);
    rd_chk(28'h10, 32'hffffffff);
    // Copy, a frame refused while busy, then a second copy
    host_u.xfer({CSP_COPY_DATA, CSP_CODE_COPY}, rx);
    tick(2);
    `CHK("busy_copy", 1'b1, busy);
    host_u.xfer({28'h0000bad, CSP_CODE_CFG0}, rx);
    tick(2);
    `CHK("cfg0_busy", K0, cfg0);
    tick(WAIT_N);
    `CHK("busy_done", 1'b0, busy);
    host_u.xfer({CSP_COPY_DATA, CSP_CODE_COPY}, rx);
    tick(2);
    `CHK("busy_again", 1'b1, busy);
    tick(WAIT_N + 10);
    host_u.xfer({28'h1111111, CSP_CODE_CFG0}, rx);
    tick(2);
    `CHK("cfg0_new", 28'h1111111, cfg0);
    // Reset in mid-run reloads the stored words
    reset_n <= 1'b0;
    tick(5);
    reset_n <= 1'b1;
    tick(8);
    `CHK("cfg0_rel", K0, cfg0);
    `CHK("cfg1_rel", K1, cfg1);
    `CHK("stat_rel", CSP_WORD_RST, stat);
    stop_test();
  end
endmodule // csp_config_port_test
